//--- rtl/ovp_bch_parity.v
`timescale 1ns/100ps
`include "ovp_defines.vh"

module ovp_bch_parity
#(
  parameter INFO_W = 28,
  parameter PAR_W = 12
)
(
  // Information bits, first sent in the top bit
  input wire [INFO_W-1:0] info,
  // Check bits
  output reg [PAR_W-1:0] parity
);

  reg [PAR_W-1:0] rem;
  reg fb;
  integer i;

  // Long division by the generator, one information bit per step.
  always @*
  begin
    rem = {PAR_W{1'b0}};
    fb = 1'b0;
    for (i = INFO_W - 1; i >= 0; i = i - 1)
    begin
      fb = info[i] ^ rem[PAR_W-1];
      rem = {rem[PAR_W-2:0], 1'b0};
      if (fb)
        rem = rem ^ `OVP_BCH_POLY;
    end
    parity = rem;
  end

endmodule

//--- rtl/ovp_defines.vh
`ifndef OVP_DEFINES_VH
`define OVP_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OVP_ADDR_W 8
`define OVP_OFF_CTRL 8'h00
`define OVP_OFF_STATUS 8'h04
`define OVP_OFF_FIELDS 8'h08
`define OVP_OFF_WORD_LO 8'h0C
`define OVP_OFF_WORD_HI 8'h10
`define OVP_OFF_PARITY 8'h14

// ----------------------------------------
// Control and status bits
// ----------------------------------------
`define OVP_CTRL_START 0
`define OVP_STAT_BUSY 0
`define OVP_STAT_DROP 1
`define OVP_STAT_CNT_LSB 16
`define OVP_STAT_CNT_MSB 31

// ----------------------------------------
// Word layout, information bits 27..0
// ----------------------------------------
`define OVP_INFO_W 28
`define OVP_PAR_W 12
`define OVP_WORD_W 40
`define OVP_BITS_LAST 6'h27
`define OVP_TYPE_MSB 27
`define OVP_TYPE_LSB 26
`define OVP_COLOR_MSB 25
`define OVP_COLOR_LSB 24
`define OVP_SERIAL_BIT 23
`define OVP_EXT_BIT 22
`define OVP_HOME_BIT 21
`define OVP_ROAM_BIT 20
`define OVP_DTX_MSB 19
`define OVP_DTX_LSB 18
`define OVP_PAGE_MSB 17
`define OVP_PAGE_LSB 13
`define OVP_FILLER_BIT 12
`define OVP_CPA_BIT 11
`define OVP_ACCESS_MSB 10
`define OVP_ACCESS_LSB 4
`define OVP_END_BIT 3
`define OVP_MTYPE_MSB 2
`define OVP_MTYPE_LSB 0

// ----------------------------------------
// Message type codes and reset values
// ----------------------------------------
`define OVP_MTYPE_GLOBAL 3'h4
`define OVP_MTYPE_WORD1 3'h6
`define OVP_MTYPE_WORD2 3'h7
`define OVP_WTYPE_RESET 2'h3
`define OVP_FIELDS_RESET 28'hC000007

// ----------------------------------------
// Parity generator, low 12 bits of the polynomial
// ----------------------------------------
`define OVP_BCH_POLY 12'h539

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define OVP_RESP_OKAY 2'h0
`define OVP_RESP_SLVERR 2'h2

`endif

//--- rtl/ovp_word2_formatter.v
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "ovp_defines.vh"

module ovp_word2_formatter
#(
  parameter ADDR_W = 8,
  parameter CNT_W = 16
)
(
  // Clock, reset and enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial word stream, first bit is the top of the word
  output reg tx_bit,
  output wire tx_valid,
  output wire tx_last,
  input wire tx_ready
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'h1;
  localparam ST_SHIFT = 3'h2;
  localparam ST_DONE = 3'h4;
  localparam [5:0] BITS_LAST = `OVP_BITS_LAST;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`OVP_INFO_W-1:0] fields_reg;
  reg [`OVP_WORD_W-1:0] word_reg;
  reg [`OVP_WORD_W-1:0] shift_reg;
  reg [5:0] bit_cnt_reg;
  reg [CNT_W-1:0] sent_cnt_reg;
  reg drop_reg;
  reg start_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg [31:0] wr_merged;
  wire [`OVP_INFO_W-1:0] info;
  wire [`OVP_PAR_W-1:0] parity;
  wire [1:0] word_type;
  wire [1:0] color_code;
  wire serial_flag;
  wire ext_flag;
  wire home_registration;
  wire roam_registration;
  wire [1:0] discontinuous_tx;
  wire [4:0] paging_count;
  wire filler_read_flag;
  wire combined_paging_access;
  wire [6:0] access_count;
  wire end_flag;
  wire [2:0] message_type;
  wire wr_do;
  wire wr_ctrl;
  wire wr_status;
  wire wr_fields;
  wire wr_known;
  wire start_req;
  wire shift_step;
  wire [31:0] status_word;

  // ----------------------------------------
  // Word fields
  // ----------------------------------------
  // word type bits
  assign word_type = fields_reg[`OVP_TYPE_MSB:`OVP_TYPE_LSB];
  assign color_code = fields_reg[`OVP_COLOR_MSB:`OVP_COLOR_LSB];
  assign serial_flag = fields_reg[`OVP_SERIAL_BIT];
  assign ext_flag = fields_reg[`OVP_EXT_BIT];
  assign home_registration = fields_reg[`OVP_HOME_BIT];
  assign roam_registration = fields_reg[`OVP_ROAM_BIT];
  assign discontinuous_tx = fields_reg[`OVP_DTX_MSB:`OVP_DTX_LSB];
  assign paging_count = fields_reg[`OVP_PAGE_MSB:`OVP_PAGE_LSB];
  assign filler_read_flag = fields_reg[`OVP_FILLER_BIT];
  assign combined_paging_access = fields_reg[`OVP_CPA_BIT];
  assign access_count = fields_reg[`OVP_ACCESS_MSB:`OVP_ACCESS_LSB];
  assign end_flag = fields_reg[`OVP_END_BIT];
  assign message_type = fields_reg[`OVP_MTYPE_MSB:`OVP_MTYPE_LSB];

  assign info = {word_type, color_code, serial_flag, ext_flag,
                 home_registration, roam_registration, discontinuous_tx,
                 paging_count, filler_read_flag, combined_paging_access,
                 access_count, end_flag, message_type};

  // ----------------------------------------
  // Parity
  // ----------------------------------------
  // shortened BCH check
  ovp_bch_parity
  #(
    .INFO_W(`OVP_INFO_W),
    .PAR_W(`OVP_PAR_W)
  )
  u_parity
  (
    .info(info),
    .parity(parity)
  );

  // ----------------------------------------
  // Register bus, write side
  // ----------------------------------------
  // Address and data are held separately so the master may offer them in either order.
  // Readies drop with the enable, so a frozen block never seems to take a request.
  assign s_axi_awready = ce & ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ce & ~w_hold_reg & ~s_axi_bvalid;
  assign wr_do = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wr_ctrl = wr_do & (aw_addr_reg == `OVP_OFF_CTRL);
  assign wr_status = wr_do & (aw_addr_reg == `OVP_OFF_STATUS);
  assign wr_fields = wr_do & (aw_addr_reg == `OVP_OFF_FIELDS);
  assign wr_known = wr_ctrl | wr_status | wr_fields |
                    (aw_addr_reg == `OVP_OFF_WORD_LO) |
                    (aw_addr_reg == `OVP_OFF_WORD_HI) |
                    (aw_addr_reg == `OVP_OFF_PARITY);

  always @*
  begin
    wr_merged = {4'h0, fields_reg};
    if (w_strb_reg[0])
      wr_merged[7:0] = w_data_reg[7:0];
    if (w_strb_reg[1])
      wr_merged[15:8] = w_data_reg[15:8];
    if (w_strb_reg[2])
      wr_merged[23:16] = w_data_reg[23:16];
    if (w_strb_reg[3])
      wr_merged[31:24] = w_data_reg[31:24];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OVP_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `OVP_RESP_OKAY : `OVP_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration and sticky status
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fields_reg <= `OVP_FIELDS_RESET;
      start_reg <= 1'b0;
      drop_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_fields)
        fields_reg <= wr_merged[`OVP_INFO_W-1:0];
      start_reg <= wr_ctrl & w_strb_reg[0] & w_data_reg[`OVP_CTRL_START];
      // A start that lands while a word is going out, or in the done cycle after it, is counted as dropped.
      if (start_req & ~state_reg[0])
        drop_reg <= 1'b1;
      else if (wr_status & w_strb_reg[0] & w_data_reg[`OVP_STAT_DROP])
        drop_reg <= 1'b0;
    end
  end

  assign start_req = start_reg;

  // ----------------------------------------
  // Word sender
  // ----------------------------------------
  assign tx_valid = state_reg[1] & ce;
  assign tx_last = tx_valid & (bit_cnt_reg == BITS_LAST);
  assign shift_step = tx_valid & tx_ready;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_req)
          state_next = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (shift_step & (bit_cnt_reg == BITS_LAST))
          state_next = ST_DONE;
      end
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      word_reg <= {`OVP_WORD_W{1'b0}};
      shift_reg <= {`OVP_WORD_W{1'b0}};
      bit_cnt_reg <= 6'h0;
      sent_cnt_reg <= {CNT_W{1'b0}};
      tx_bit <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      if (state_reg[0] & start_req)
      begin
        word_reg <= {info, parity};
        shift_reg <= {info[`OVP_INFO_W-2:0], parity, 1'b0};
        tx_bit <= info[`OVP_INFO_W-1];
        bit_cnt_reg <= 6'h0;
      end
      else if (shift_step)
      begin
        tx_bit <= shift_reg[`OVP_WORD_W-1];
        shift_reg <= {shift_reg[`OVP_WORD_W-2:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + 6'h1;
      end
      if (state_reg[2])
        sent_cnt_reg <= sent_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Register bus, read side
  // ----------------------------------------
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign status_word = {sent_cnt_reg, 14'h0, drop_reg, ~state_reg[0]};

  always @*
  begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OVP_OFF_CTRL:
        rd_mux = 32'h0;
      `OVP_OFF_STATUS:
        rd_mux = status_word;
      `OVP_OFF_FIELDS:
        rd_mux = {4'h0, fields_reg};
      `OVP_OFF_WORD_LO:
        rd_mux = word_reg[31:0];
      `OVP_OFF_WORD_HI:
        rd_mux = {24'h0, word_reg[`OVP_WORD_W-1:32]};
      `OVP_OFF_PARITY:
        rd_mux = {20'h0, parity};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `OVP_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `OVP_RESP_OKAY : `OVP_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- tb/ovp_chk_asserts.sv
`timescale 1ns/100ps
module ovp_chk (
  // Clock, reset and enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // Bus answers
  input wire s_axi_arready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Serial stream
  input wire tx_bit,
  input wire tx_valid,
  input wire tx_last,
  input wire tx_ready
);
  reg [5:0] n_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Counts accepted bits so the end marker can be tied to bit forty.
  always @(posedge aclk)
    if (!aresetn)
      n_reg <= 6'h00;
    else if (ce && !tx_valid)
      n_reg <= 6'h00;
    else if (ce && tx_ready)
      n_reg <= n_reg + 6'h01;
  chk_frame_len:
  assert property (tx_valid |-> (tx_last == (n_reg == 6'h27))) else $error("end bit misplaced");
  chk_bit_hold:
  assert property (tx_valid && !tx_ready |=> (tx_valid || !ce) && $stable(tx_bit))
    else $error("bit not held");
  chk_frame_end:
  assert property (tx_valid && tx_last && tx_ready && ce |=> !tx_valid) else $error("word overran");
  chk_last_inside:
  assert property (tx_last |-> tx_valid) else $error("end marker outside word");
  chk_b_hold:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_hold:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_ar_ready:
  assert property (s_axi_arready == (ce && !s_axi_rvalid)) else $error("read address ready wrong");
  chk_b_done:
  assert property (s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid) else $error("answer repeated");
  cover property (tx_valid && !tx_ready);
  cover property (tx_last && tx_ready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (tx_valid ##1 !ce);
endmodule

//--- tb/ovp_sink.sv
`timescale 1ns/100ps
module ovp_sink (
  // Clock, reset and stall mode
  input wire aclk,
  input wire aresetn,
  input wire slow,
  // Serial stream
  input wire tx_bit,
  input wire tx_valid,
  input wire tx_last,
  output reg tx_ready,
  // Collected words
  output reg [39:0] word,
  output reg [15:0] cnt
);
  reg [38:0] sh;
  reg [1:0] ph;
  // When slow, stalls two cycles in four, as a busy receiver would.
  always @(posedge aclk)
    if (!aresetn)
    begin
      ph <= 2'h0;
      cnt <= 16'h0000;
      tx_ready <= 1'b0;
    end
    else
    begin
      ph <= ph + 2'h1;
      tx_ready <= !slow || ph[1];
      if (tx_valid && tx_ready)
      begin
        sh <= {sh[37:0], tx_bit};
        if (tx_last)
        begin
          word <= {sh, tx_bit};
          cnt <= cnt + 16'h0001;
        end
      end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
`include "ovp_defines.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  reg aclk = 0, aresetn = 0, slow = 0, ce = 1;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, d;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, tx_bit, tx_valid, tx_last, tx_ready;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [39:0] word;
  wire [15:0] cnt;
  integer mismatches = 0, cmp_count = 0;
  ovp_word2_formatter i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
  ovp_sink i_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_bit(tx_bit),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .word(word), .cnt(cnt));
  initial
    forever #5 aclk = ~aclk;
  // Expected check bits: remainder of the info word shifted by twelve.
  function [11:0] bch(input [27:0] f);
    reg [11:0] p;
    integer i;
  begin
    p = 12'h000;
    for (i = 27; i >= 0; i--)
      p = {p[10:0], 1'b0} ^ ((f[i] ^ p[11]) ? `OVP_BCH_POLY : 12'h000);
    bch = p;
  end
  endfunction
  task wr(input [7:0] a, input [31:0] v, output [1:0] resp);
    integer i;
    reg done;
  begin
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    done = 0;
    for (i = 0; i < 100 && !done; i++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 0;
        done = 1;
      end
    end
    if (!done)
      mismatches++;
  end
  endtask
  task rd(input [7:0] a, output [31:0] v, output [1:0] resp);
    integer i;
    reg done;
  begin
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    done = 0;
    for (i = 0; i < 100 && !done; i++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
      if (rvalid)
      begin
        v = rdata;
        resp = rresp;
        rready <= 0;
        done = 1;
      end
    end
    if (!done)
      mismatches++;
  end
  endtask
  task idle;
    integer i;
  begin
    d = 32'h1;
    for (i = 0; i < 200 && d[0]; i++)
      rd(`OVP_OFF_STATUS, d, r);
    if (d[0])
      mismatches++;
  end
  endtask
  task t_reset;
  begin
    rd(`OVP_OFF_FIELDS, d, r);
    `CHK("fields", {4'h0, `OVP_FIELDS_RESET}, d)
    rd(`OVP_OFF_STATUS, d, r);
    `CHK("status", 2'h0, d[1:0])
    rd(8'h20, d, r);
    `CHK("unmapped", `OVP_RESP_SLVERR, r)
    `CHK("unmapped_data", 32'h0, d)
    wr(8'h20, 32'h0, r);
    `CHK("wr_unmapped", `OVP_RESP_SLVERR, r)
  end
  endtask
  task t_word(input [27:0] f, input s);
    reg [15:0] n;
  begin
    slow <= s;
    n = cnt;
    wr(`OVP_OFF_FIELDS, {4'h0, f}, r);
    wr(`OVP_OFF_PARITY, 32'hFFF, r);
    `CHK("par_wr", `OVP_RESP_OKAY, r)
    rd(`OVP_OFF_PARITY, d, r);
    `CHK("parity", {20'h0, bch(f)}, d)
    wr(`OVP_OFF_CTRL, 32'h1, r);
    idle;
    `CHK("words", n + 16'h1, cnt)
    `CHK("word", {f, bch(f)}, word)
    rd(`OVP_OFF_WORD_HI, d, r);
    `CHK("word_hi", {24'h0, f[27:20]}, d)
    rd(`OVP_OFF_WORD_LO, d, r);
    `CHK("word_lo", {f[19:0], bch(f)}, d)
  end
  endtask
  task t_freeze;
    reg [15:0] n;
  begin
    n = cnt;
    wr(`OVP_OFF_CTRL, 32'h1, r);
    repeat (10) @(posedge aclk);
    ce <= 0;
    repeat (8) @(posedge aclk);
    `CHK("frozen", 1'b0, tx_valid)
    `CHK("held", n, cnt)
    ce <= 1;
    idle;
    `CHK("freeze_words", n + 16'h1, cnt)
    `CHK("freeze_word", {28'h123456C, bch(28'h123456C)}, word)
  end
  endtask
  task t_drop;
    reg [15:0] n;
  begin
    n = cnt;
    wr(`OVP_OFF_CTRL, 32'h1, r);
    wr(`OVP_OFF_CTRL, 32'h1, r);
    idle;
    `CHK("one_word", n + 16'h1, cnt)
    `CHK("drop", 1'b1, d[1])
    `CHK("sent", n + 16'h1, d[31:16])
    wr(`OVP_OFF_STATUS, 32'h2, r);
    rd(`OVP_OFF_STATUS, d, r);
    `CHK("drop_clr", 1'b0, d[1])
  end
  endtask
  task stop_test;
  begin
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_word(28'hFFFFFFF, 0);
    t_word(28'h0000006, 1);
    t_word(28'h9B3E2A4, 1);
    t_word(28'h123456C, 0);
    t_drop;
    t_freeze;
    stop_test;
  end
endmodule
bind ovp_word2_formatter ovp_chk i_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready));
